// ---- src/genset_mode_alarm_sequencer.sv ----
// Operating mode, start/stop sequence, fault priority and service sets.
// Assumes panel and plant pins are asynchronous; config is static.
// How it works
// RULE1: Run key held five seconds selects test
// RULE2: Stop unloads, cools down; second stop halts
// RULE3: Engine still turning after confirm: warning
// RULE4: Mains contactor only with healthy mains
// RULE5: Stop mode ignores every start request
// RULE6: Panel lock freezes the operating mode
// RULE7: Mains availability with override priority chain
// RULE8: Outage confirm delay; mains return aborts
// RULE9: Fuel, preheat, then crank attempts, cut
// RULE10: Idle, warm up, check alternator, then load
// RULE11: Mains return: settle, swap contactors delayed
// RULE12: Cool down at idle, stop coil, rearm (idle speed only for the last TIMERS.idle seconds of S_COOL)
// RULE13: Schedule block flashes auto lamp, stops
// RULE14: Run mode runs unloaded; backup swaps
// RULE15: Test mode runs and carries the load
// RULE16: Three fault levels drive lamps, relays
// RULE17: First fault wins; lower ones rejected (a later higher fault still latches and acts)
// RULE18: Silence drops alarm output only
// RULE19: Sticky faults hold; mode key clears
// RULE20: Protection override turns faults into warnings
// RULE21: Three service sets, hours and days
// RULE22: Service due flashes; two keys clear
// RULE23: All timers count a one second tick
`timescale 1ns/1ps
module genset_mode_alarm_sequencer
   import genset_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)(
   input  wire logic     CLK,
   input  wire logic     RESET,
   input  wire pins_t    PINS,
   input  wire cfg_t     CFG,
   input  wire timers_t  TIMERS,
   input  wire svc_lim_t SVC_LIMITS,
   output      mode_t    MODE,
   output      relays_t  RELAYS,
   output      lamps_t   LAMPS
);

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   // =====================================================================
   // Second tick and flash
   logic [31:0] tick_cnt_ff;
   logic        tick;
   logic        blink_ff;

   assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1)); // RULE23

   always_ff @(posedge CLK) begin
      if (RESET || tick) begin
         tick_cnt_ff <= 32'h0000_0000;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         blink_ff <= 1'b0;
      end else if (tick) begin
         blink_ff <= ~blink_ff;
      end
   end

   // =====================================================================
   // Pin synchroniser and key edges
   pins_t meta_ff, pin_ff, prev_ff;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         meta_ff <= '0;
         pin_ff  <= '0;
         prev_ff <= '0;
      end else begin
         meta_ff <= PINS;
         pin_ff  <= meta_ff;
         prev_ff <= pin_ff;
      end
   end

   logic stop_press, auto_press, run_release, silence_press;
   assign stop_press    = pin_ff.stop_key & ~prev_ff.stop_key;
   assign auto_press    = pin_ff.auto_key & ~prev_ff.auto_key;
   assign run_release   = ~pin_ff.run_key & prev_ff.run_key;
   assign silence_press = pin_ff.silence_key & ~prev_ff.silence_key;

   // =====================================================================
   // Operating mode
   logic [2:0] hold_cnt_ff;
   logic       hold_done_ff;
   logic       test_pick, run_pick, lock, mode_press;
   mode_t      mode_ff;

   assign test_pick = pin_ff.run_key & tick & ~hold_done_ff
                    & (hold_cnt_ff == 3'(TEST_HOLD_S - 1)); // RULE1
   assign run_pick   = run_release & ~hold_done_ff; // RULE1
   assign lock       = CFG.lock_en & pin_ff.panel_lock;
   assign mode_press = stop_press | auto_press | test_pick | run_pick;

   always_ff @(posedge CLK) begin
      if (RESET || !pin_ff.run_key) begin
         hold_cnt_ff  <= 3'h0;
         hold_done_ff <= 1'b0;
      end else if (tick && !hold_done_ff) begin
         hold_cnt_ff  <= hold_cnt_ff + 3'h1;
         hold_done_ff <= test_pick;
      end
   end

   // Lock blocks changes only; display keys are outside this block
   always_ff @(posedge CLK) begin
      if (RESET) begin
         mode_ff <= M_STOP;
      end else if (!lock) begin // RULE6
         if (stop_press) begin
            mode_ff <= M_STOP;
         end else if (auto_press) begin
            mode_ff <= M_AUTO;
         end else if (test_pick) begin
            mode_ff <= M_TEST; // RULE1
         end else if (run_pick) begin
            mode_ff <= M_RUN;
         end
      end
   end

   a_test_hold_mode: assert property (test_pick && !lock |=> // RULE1
      mode_ff == M_TEST) else $error("test hold did not select test");
   a_lock_holds_mode: assert property (lock |=> $stable(mode_ff)) // RULE6
      else $error("mode changed under panel lock");

   // =====================================================================
   // Mains and alternator evaluation
   logic mains_ok, avail, gen_ok, sched;

   assign mains_ok = pin_ff.mains_volt_ok & pin_ff.mains_freq_ok
                   & (pin_ff.mains_order_ok | ~CFG.order_check_en); // RULE4
   assign gen_ok   = pin_ff.gen_volt_ok & pin_ff.gen_freq_ok
                   & pin_ff.gen_order_ok; // RULE10
   assign sched    = pin_ff.sched_disable & (mode_ff == M_AUTO); // RULE13

   always_comb begin
      avail = pin_ff.mains_volt_ok & pin_ff.mains_freq_ok; // RULE7
      if (pin_ff.mains_override) begin
         avail = 1'b1;
      end
      if (pin_ff.forced_run_request) begin
         avail = 1'b0;
      end
      if (CFG.ext_run_en) begin
         avail = ~pin_ff.ext_run;
      end
   end

   // =====================================================================
   // Faults
   logic [N_SVC-1:0] svc_due;
   logic shd_ff, ldd_ff, wrn_ff, muted_ff, halt_fail_ff;
   logic shd_src, ldd_src, wrn_src, svc_shd, svc_ldd, svc_wrn;
   logic nxt_shd, nxt_ldd, nxt_wrn, new_fault;

   always_comb begin
      svc_shd = 1'b0;
      svc_ldd = 1'b0;
      svc_wrn = 1'b0;
      for (int i = 0; i < N_SVC; i++) begin // RULE22
         svc_shd |= svc_due[i] & (CFG.svc_level[i] == LVL_SHD);
         svc_ldd |= svc_due[i] & (CFG.svc_level[i] == LVL_LDD);
         svc_wrn |= svc_due[i] & (CFG.svc_level[i] == LVL_WARN);
      end
   end

   // Override demotes trips; they still show on the warning lamp
   assign shd_src = ~pin_ff.protect_override
                  & (pin_ff.fault_shutdown | svc_shd); // RULE20
   assign ldd_src = ~pin_ff.protect_override
                  & (pin_ff.fault_loaddump | svc_ldd);
   assign wrn_src = pin_ff.fault_warning | svc_wrn | halt_fail_ff
                  | (pin_ff.protect_override & (pin_ff.fault_shutdown
                  | svc_shd | pin_ff.fault_loaddump | svc_ldd));

   // A present source wins over the mode key clear
   assign nxt_shd = shd_src | (shd_ff & ~(mode_press // RULE19
                  | (~CFG.sticky[STK_SHD] & ~shd_src)));
   assign nxt_ldd = (ldd_src & ~shd_ff) | (ldd_ff & ~(mode_press // RULE17
                  | (~CFG.sticky[STK_LDD] & ~ldd_src)));
   assign nxt_wrn = (wrn_src & ~shd_ff & ~ldd_ff) | (wrn_ff & ~(mode_press
                  | (~CFG.sticky[STK_WRN] & ~wrn_src)));
   assign new_fault = (nxt_shd & ~shd_ff) | (nxt_ldd & ~ldd_ff)
                    | (nxt_wrn & ~wrn_ff);

   always_ff @(posedge CLK) begin
      if (RESET) begin
         shd_ff <= 1'b0;
         ldd_ff <= 1'b0;
         wrn_ff <= 1'b0;
      end else begin
         shd_ff <= nxt_shd;
         ldd_ff <= nxt_ldd;
         wrn_ff <= nxt_wrn;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET || new_fault) begin
         muted_ff <= 1'b0;
      end else if (silence_press) begin
         muted_ff <= 1'b1; // RULE18
      end
   end

   a_fault_priority: assert property (shd_ff |=> !$rose(ldd_ff)) // RULE17
      else $error("load dump taken during shutdown");
   a_sticky_hold: assert property (shd_ff && CFG.sticky[STK_SHD] // RULE19
      && !mode_press |=> shd_ff) else $error("sticky shutdown lost");
   a_override_demote: assert property (pin_ff.protect_override // RULE20
      && !shd_ff |=> !shd_ff) else $error("shutdown under override");
   a_silence_alarm: assert property (muted_ff |=> !RELAYS.alarm) // RULE18
      else $error("alarm output while silenced");

   // =====================================================================
   // Start and stop sequence
   seq_t          state_ff, nxt_state;
   logic [TW-1:0] tmr_ff, dur;
   logic [3:0]    tries_ff;
   logic          want_run, want_load, inhibit, done, running;

   assign want_run  = (mode_ff == M_RUN) | (mode_ff == M_TEST) // RULE14
                    | ((mode_ff == M_AUTO) & ~sched & ~avail); // RULE5
   assign want_load = (mode_ff == M_TEST) // RULE15
                    | ((mode_ff == M_AUTO) & ~sched & ~avail)
                    | ((mode_ff == M_RUN) & CFG.backup_en & ~avail);
   assign inhibit   = shd_ff | ldd_ff;
   assign done      = (tmr_ff == '0);
   // Fuel stays off while an outage is still being confirmed
   assign running   = (state_ff != S_REST) & (state_ff != S_WAIT)
                    & (state_ff != S_HALT);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         S_REST: if (want_run && !inhibit) begin
            nxt_state = (mode_ff == M_AUTO) ? S_WAIT : S_PREHEAT;
         end
         S_WAIT: if (!want_run || inhibit) begin
            nxt_state = S_REST; // RULE8
         end else if (done) begin
            nxt_state = S_PREHEAT;
         end
         S_PREHEAT: if (done) begin
            nxt_state = S_CRANK; // RULE9
         end
         S_CRANK: if (pin_ff.engine_fired) begin
            nxt_state = S_IDLE; // RULE9
         end else if (done) begin
            nxt_state = (tries_ff >= CFG.crank_tries) ? S_HALT : S_PAUSE;
         end
         S_PAUSE: if (done) begin
            nxt_state = S_CRANK;
         end
         S_IDLE: if (done) begin
            nxt_state = S_WARM; // RULE10
         end
         S_WARM: if (done && want_load && gen_ok) begin
            nxt_state = S_GEN_DLY; // RULE10
         end
         S_GEN_DLY: if (!want_load || !gen_ok) begin
            nxt_state = S_WARM;
         end else if (done) begin
            nxt_state = S_LOADED;
         end
         S_LOADED: if (!want_load) begin // RULE2
            nxt_state = (want_run || (mode_ff == M_AUTO && !sched))
                      ? S_SETTLE : S_COOL; // RULE11
         end
         S_SETTLE: if (want_load) begin
            nxt_state = S_LOADED;
         end else if (done) begin
            nxt_state = want_run ? S_WARM : S_COOL; // RULE11
         end
         S_COOL: if (done || (stop_press && mode_ff == M_STOP)) begin
            nxt_state = S_HALT; // RULE2
         end
         S_HALT: if (done) begin
            nxt_state = S_REST; // RULE12
         end
         default: nxt_state = S_REST;
      endcase
      // Demand loss during start stops at once; once idling it cools
      if (!want_run && (state_ff == S_PREHEAT || state_ff == S_CRANK
          || state_ff == S_PAUSE)) begin
         nxt_state = S_HALT;
      end
      if (!want_run && (state_ff == S_IDLE || state_ff == S_WARM
          || state_ff == S_GEN_DLY)) begin
         nxt_state = S_COOL;
      end
      if (ldd_ff && running && state_ff != S_COOL) begin
         nxt_state = S_COOL; // RULE16
      end
      if (shd_ff && running) begin
         nxt_state = S_HALT; // RULE16
      end
   end

   always_comb begin
      case (nxt_state)
         S_WAIT:    dur = TIMERS.start_dly;
         S_PREHEAT: dur = TIMERS.preheat;
         S_CRANK:   dur = TIMERS.crank;
         S_PAUSE:   dur = TIMERS.crank;
         S_IDLE:    dur = TIMERS.idle;
         S_WARM:    dur = TIMERS.warmup;
         S_GEN_DLY: dur = TIMERS.gen_dly;
         S_SETTLE:  dur = TIMERS.settle;
         S_COOL:    dur = TIMERS.cool;
         S_HALT:    dur = TIMERS.stop_coil;
         default:   dur = '0;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_ff <= S_REST;
         tmr_ff   <= '0;
      end else begin
         state_ff <= nxt_state;
         if (nxt_state != state_ff) begin
            tmr_ff <= dur;
         end else if (tick && !done) begin
            tmr_ff <= tmr_ff - 1'b1; // RULE23
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET || state_ff == S_REST) begin
         tries_ff <= 4'h0;
      end else if (nxt_state == S_CRANK && state_ff != S_CRANK) begin
         tries_ff <= tries_ff + 4'h1; // RULE9
      end
   end

   sequence crank_cut_s;
      state_ff == S_IDLE ##1 !RELAYS.crank;
   endsequence
   a_crank_cut: assert property (state_ff == S_CRANK // RULE9
      && pin_ff.engine_fired && want_run && !inhibit |=> crank_cut_s)
      else $error("crank not cut after firing");
   a_outage_abort: assert property (state_ff == S_WAIT && avail // RULE8
      && mode_ff == M_AUTO |=> state_ff == S_REST)
      else $error("start kept after mains return");
   a_stop_no_start: assert property (mode_ff == M_STOP // RULE5
      && state_ff == S_REST |=> state_ff == S_REST)
      else $error("engine started in stop mode");

   // =====================================================================
   // Stop confirmation and mains contactor delay
   logic [TW-1:0] conf_cnt_ff, mdly_ff;
   logic          conf_ff, conf_expire, gen_on;

   assign conf_expire = conf_ff & tick & (conf_cnt_ff == '0);
   assign gen_on = ((state_ff == S_LOADED) | (state_ff == S_SETTLE))
                 & ~inhibit; // RULE16

   always_ff @(posedge CLK) begin
      if (RESET) begin
         conf_ff     <= 1'b0;
         conf_cnt_ff <= '0;
      end else if (nxt_state == S_HALT && state_ff != S_HALT) begin
         conf_ff     <= 1'b1;
         conf_cnt_ff <= TIMERS.stop_confirm;
      end else if (conf_ff && tick) begin
         conf_ff     <= ~conf_expire;
         conf_cnt_ff <= conf_cnt_ff - {{(TW-1){1'b0}}, ~conf_expire};
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         halt_fail_ff <= 1'b0;
      end else begin
         halt_fail_ff <= (conf_expire & pin_ff.engine_fired) // RULE3
                       | (halt_fail_ff & ~mode_press);
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET || gen_on) begin
         mdly_ff <= TIMERS.mains_dly; // RULE11
      end else if (tick && mdly_ff != '0) begin
         mdly_ff <= mdly_ff - 1'b1;
      end
   end

   a_halt_fail_flag: assert property (conf_expire // RULE3
      && pin_ff.engine_fired |=> halt_fail_ff)
      else $error("failure to stop not raised");

   // =====================================================================
   // Service sets
   logic [2:0] svc_hold_ff;
   logic       svc_hold_done_ff, svc_clear;

   assign svc_clear = pin_ff.silence_key & pin_ff.indicator_check_key
                    & tick & ~svc_hold_done_ff
                    & (svc_hold_ff == 3'(SVC_HOLD_S - 1)); // RULE22

   always_ff @(posedge CLK) begin
      if (RESET || !(pin_ff.silence_key && pin_ff.indicator_check_key))
      begin
         svc_hold_ff      <= 3'h0;
         svc_hold_done_ff <= 1'b0;
      end else if (tick && !svc_hold_done_ff) begin
         svc_hold_ff      <= svc_hold_ff + 3'h1;
         svc_hold_done_ff <= svc_clear;
      end
   end

   for (genvar i = 0; i < N_SVC; i++) begin : g_svc
      logic [11:0]   hsec_ff;
      logic [16:0]   dsec_ff;
      logic [TW-1:0] hrs_ff, days_ff;
      logic          hwrap, dwrap;
      assign hwrap = (hsec_ff == 12'(SEC_PER_HOUR - 1));
      assign dwrap = (dsec_ff == 17'(SEC_PER_DAY - 1));
      // Zero limit disables that half; both zero leaves the set idle
      assign svc_due[i] = // RULE21
         ((SVC_LIMITS.hours[i] != '0) && (hrs_ff >= SVC_LIMITS.hours[i]))
         || ((SVC_LIMITS.days[i] != '0) && (days_ff >= SVC_LIMITS.days[i]));
      always_ff @(posedge CLK) begin
         if (RESET || svc_clear) begin
            hsec_ff <= '0;
            dsec_ff <= '0;
            hrs_ff  <= '0;
            days_ff <= '0;
         end else if (tick) begin
            dsec_ff <= dwrap ? '0 : dsec_ff + 17'h0_0001;
            days_ff <= days_ff + {{(TW-1){1'b0}}, dwrap};
            if (pin_ff.engine_fired) begin
               hsec_ff <= hwrap ? '0 : hsec_ff + 12'h001;
               hrs_ff  <= hrs_ff + {{(TW-1){1'b0}}, hwrap};
            end
         end
      end
   end

   // =====================================================================
   // Registered outputs
   always_ff @(posedge CLK) begin
      if (RESET) begin
         RELAYS <= '0;
         LAMPS  <= '0;
      end else begin
         RELAYS.fuel       <= running;
         RELAYS.preheat    <= (state_ff == S_PREHEAT); // RULE9
         RELAYS.crank      <= (state_ff == S_CRANK) & ~pin_ff.engine_fired;
         RELAYS.idle_speed <= (state_ff == S_IDLE) // RULE12
                            | ((state_ff == S_COOL) & (tmr_ff <= TIMERS.idle));
         RELAYS.stop_coil  <= (state_ff == S_HALT); // RULE12
         RELAYS.gen_contactor   <= gen_on;
         RELAYS.mains_contactor <= ~gen_on & mains_ok // RULE4
                                 & (mdly_ff == '0);
         RELAYS.alarm      <= (shd_ff | ldd_ff | wrn_ff) & ~muted_ff;
         RELAYS.service    <= |svc_due; // RULE22
         LAMPS.alarm_lamp  <= shd_ff | ldd_ff; // RULE16
         LAMPS.warn_lamp   <= wrn_ff;
         LAMPS.auto_lamp   <= (mode_ff == M_AUTO)
                            & (~pin_ff.sched_disable | blink_ff); // RULE13
         LAMPS.service_lamp <= (|svc_due) & blink_ff;
         LAMPS.halt_failure_warning <= halt_fail_ff;
      end
   end

   assign MODE = mode_ff;

   a_mains_contact: assert property (RELAYS.mains_contactor // RULE4
      |-> $past(mains_ok)) else $error("mains contactor on bad mains");
   a_shd_opens_gen: assert property (shd_ff // RULE16
      |=> !RELAYS.gen_contactor) else $error("generator loaded in shutdown");
   a_stop_unload: assert property (state_ff == S_LOADED // RULE2
      && mode_ff == M_STOP |=> state_ff inside {S_COOL, S_HALT})
      else $error("load kept in stop mode");

endmodule : genset_mode_alarm_sequencer

// ---- src/genset_pkg.sv ----
// Shared constants and types of the genset mode and alarm sequencer.
// Assumes a single system clock and synchronous active high reset.
package genset_pkg;

   // =====================================================================
   // Timing
   localparam int unsigned CLK_PERIOD_NS   = 32'h0000_0019;
   localparam int unsigned TICK_PERIOD_NS  = 32'h3B9A_CA00; // one second
   localparam int unsigned TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned TEST_HOLD_S     = 32'h0000_0005;
   localparam int unsigned SVC_HOLD_S      = 32'h0000_0005;
   localparam int unsigned SEC_PER_HOUR    = 32'h0000_0E10;
   localparam int unsigned SEC_PER_DAY     = 32'h0001_5180;
   localparam int unsigned TW              = 32'h0000_0010;
   localparam int unsigned N_SVC           = 32'h0000_0003;

   // =====================================================================
   // Fault levels and sticky field positions
   localparam logic [1:0] LVL_WARN = 2'h1;
   localparam logic [1:0] LVL_LDD  = 2'h2;
   localparam logic [1:0] LVL_SHD  = 2'h3;
   localparam int unsigned STK_WRN = 32'h0000_0000;
   localparam int unsigned STK_LDD = 32'h0000_0001;
   localparam int unsigned STK_SHD = 32'h0000_0002;

   // =====================================================================
   // Types
   typedef enum logic [1:0] {
      M_STOP = 2'h0, M_AUTO = 2'h1, M_RUN = 2'h3, M_TEST = 2'h2
   } mode_t;

   typedef enum logic [3:0] {
      S_REST  = 4'h0, S_WAIT   = 4'h1, S_PREHEAT = 4'h3, S_CRANK  = 4'h2,
      S_PAUSE = 4'h6, S_IDLE   = 4'h7, S_WARM    = 4'h5, S_GEN_DLY = 4'h4,
      S_LOADED = 4'hC, S_SETTLE = 4'hD, S_COOL   = 4'hF, S_HALT   = 4'hE
   } seq_t;

   typedef struct packed {
      logic stop_key, auto_key, run_key, silence_key, indicator_check_key;
      logic panel_lock, mains_volt_ok, mains_freq_ok, mains_order_ok;
      logic mains_override, forced_run_request, ext_run, engine_fired;
      logic gen_volt_ok, gen_freq_ok, gen_order_ok, sched_disable;
      logic protect_override, fault_shutdown, fault_loaddump, fault_warning;
   } pins_t;

   typedef struct packed {
      logic                       lock_en, order_check_en, ext_run_en;
      logic                       backup_en;
      logic [2:0]                 sticky;
      logic [3:0]                 crank_tries;
      logic [N_SVC-1:0][1:0]      svc_level;
   } cfg_t;

   typedef struct packed {
      logic [TW-1:0] start_dly, preheat, crank, idle, warmup, gen_dly;
      logic [TW-1:0] settle, mains_dly, cool, stop_coil, stop_confirm;
   } timers_t;

   typedef struct packed {
      logic [N_SVC-1:0][TW-1:0] hours;
      logic [N_SVC-1:0][TW-1:0] days;
   } svc_lim_t;

   typedef struct packed {
      logic fuel, preheat, crank, idle_speed, stop_coil;
      logic gen_contactor, mains_contactor, alarm, service;
   } relays_t;

   typedef struct packed {
      logic alarm_lamp, warn_lamp, auto_lamp, service_lamp;
      logic halt_failure_warning;
   } lamps_t;

endpackage : genset_pkg

// ---- verification/engine_model.sv ----
// Engine model: fires after some cranking, runs while fueled.
// Assumes the sequencer relays on the same clock.
`timescale 1ns/1ps
module engine_model
   import genset_pkg::*;
(
   input  wire logic    CLK,
   input  wire logic    RESET,
   input  wire relays_t RELAYS,
   output logic         FIRED
);
   // ==========================================
   // Engine
   logic [2:0] crank_ff;
   always_ff @(posedge CLK) begin
      if (RESET || !RELAYS.crank) crank_ff <= 3'h0;
      else if (crank_ff != 3'h4) crank_ff <= crank_ff + 3'h1;
   end
   // Not instant: a crank blip alone never starts it
   always_ff @(posedge CLK) begin
      if (RESET) FIRED <= 1'b0;
      else FIRED <= RELAYS.fuel && (FIRED || crank_ff == 3'h4);
   end
endmodule : engine_model

// ---- verification/testbench.sv ----
// Self-checking bench for the genset sequencer.
// Assumes the engine model drives the fired pin; fast tick.
`timescale 1ns/1ps
module testbench;
   import genset_pkg::*;
   logic        CLK, RESET, fired;
   logic [20:0] p;
   pins_t       pins;
   cfg_t        cfg;
   timers_t     tmr;
   mode_t       MODE;
   relays_t     RELAYS;
   lamps_t      LAMPS;
   int          num_errors, samples_checked;
   // ==========================================
   // Plant
   always_comb begin
      pins = pins_t'(p);
      pins.engine_fired = fired;
   end
   genset_mode_alarm_sequencer #(.TICK_CYCLES(8)) u_dut (
      .CLK(CLK), .RESET(RESET), .PINS(pins), .CFG(cfg), .TIMERS(tmr),
      .SVC_LIMITS('0), .MODE(MODE), .RELAYS(RELAYS), .LAMPS(LAMPS));
   engine_model u_eng (.CLK(CLK), .RESET(RESET), .RELAYS(RELAYS),
      .FIRED(fired));
   // ==========================================
   // Helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask : cyc
   task automatic key(input int b, input int n);
      @(posedge CLK);
      p[b] <= 1'b1;
      cyc(n);
      @(posedge CLK);
      p[b] <= 1'b0;
      cyc(12);
   endtask : key
   task automatic wrap_up;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   // ==========================================
   // Scenarios
   task automatic t_stop_mode;
      cyc(80);
      chk(RELAYS.mains_contactor, 1'b1);
      @(posedge CLK);
      p[13] <= 1'b0;
      cyc(6);
      chk(RELAYS.mains_contactor, 1'b0);
      @(posedge CLK);
      p[13] <= 1'b1;
      p[10:9] <= 2'h3;
      cyc(300);
      chk(RELAYS.fuel, 1'b0);
      @(posedge CLK);
      p[10:9] <= 2'h0;
      p[15] <= 1'b1;
      key(19, 4);
      chk(MODE, M_STOP);
      @(posedge CLK);
      p[15] <= 1'b0;
      $display("test stop_mode done");
   endtask : t_stop_mode
   task automatic t_faults;
      @(posedge CLK);
      p[2] <= 1'b1;
      cyc(8);
      chk({RELAYS.alarm, LAMPS.alarm_lamp}, 2'h3);
      @(posedge CLK);
      p[0] <= 1'b1;
      cyc(8);
      chk(LAMPS.warn_lamp, 1'b0);
      key(17, 4);
      chk({RELAYS.alarm, LAMPS.alarm_lamp}, 2'h1);
      @(posedge CLK);
      p[2] <= 1'b0;
      p[0] <= 1'b0;
      cyc(8);
      chk(LAMPS.alarm_lamp, 1'b1);
      key(20, 4);
      chk({RELAYS.alarm, LAMPS.alarm_lamp}, 2'h0);
      @(posedge CLK);
      p[3] <= 1'b1;
      p[2] <= 1'b1;
      cyc(8);
      chk({LAMPS.warn_lamp, LAMPS.alarm_lamp}, 2'h2);
      @(posedge CLK);
      p[3] <= 1'b0;
      p[2] <= 1'b0;
      cyc(8);
      $display("test faults done");
   endtask : t_faults
   task automatic t_auto;
      logic lamp_was;
      key(19, 4);
      chk(MODE, M_AUTO);
      @(posedge CLK);
      p[4] <= 1'b1;
      p[9] <= 1'b1;
      cyc(8);
      lamp_was = LAMPS.auto_lamp;
      cyc(8);
      chk({RELAYS.fuel, LAMPS.auto_lamp}, {1'b0, ~lamp_was});
      @(posedge CLK);
      p[4] <= 1'b0;
      cyc(6);
      chk(RELAYS.fuel, 1'b0);
      @(posedge CLK);
      p[9] <= 1'b0;
      cyc(30);
      chk({RELAYS.fuel, RELAYS.stop_coil}, 2'h0);
      @(posedge CLK);
      p[9] <= 1'b1;
      for (int i = 0; i < 3000 && RELAYS.gen_contactor !== 1'b1; i++) cyc(1);
      chk({RELAYS.gen_contactor, RELAYS.mains_contactor}, 2'h2);
      @(posedge CLK);
      p[9] <= 1'b0;
      cyc(6);
      chk(RELAYS.gen_contactor, 1'b1);
      for (int i = 0; i < 3000 && RELAYS.gen_contactor !== 1'b0; i++) cyc(1);
      cyc(4);
      chk({RELAYS.fuel, RELAYS.mains_contactor}, 2'h2);
      cyc(30);
      chk({RELAYS.fuel, RELAYS.mains_contactor}, 2'h3);
      key(20, 4);
      key(20, 4);
      chk(RELAYS.fuel, 1'b0);
      $display("test auto done");
   endtask : t_auto
   task automatic t_run;
      key(18, 4);
      chk(MODE, M_RUN);
      for (int i = 0; i < 2000 && fired !== 1'b1; i++) cyc(1);
      cyc(6);
      chk({RELAYS.fuel, RELAYS.crank}, 2'h2);
      cyc(400);
      chk({RELAYS.fuel, RELAYS.gen_contactor}, 2'h2);
      key(20, 4);
      chk(MODE, M_STOP);
      for (int i = 0; i < 2000 && RELAYS.fuel !== 1'b0; i++) cyc(1);
      cyc(2);
      chk(RELAYS.stop_coil, 1'b1);
      cyc(60);
      $display("test run done");
   endtask : t_run
   task automatic t_test;
      key(18, 60);
      chk(MODE, M_TEST);
      for (int i = 0; i < 3000 && RELAYS.gen_contactor !== 1'b1; i++) cyc(1);
      chk({RELAYS.gen_contactor, RELAYS.mains_contactor}, 2'h2);
      key(20, 4);
      chk({RELAYS.gen_contactor, RELAYS.fuel}, 2'h1);
      key(20, 4);
      chk(RELAYS.fuel, 1'b0);
      $display("test test_mode done");
   endtask : t_test
   // ==========================================
   // Run control
   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   initial begin
      repeat (30000) @(posedge CLK);
      num_errors++;
      wrap_up();
   end
   initial begin
      num_errors = 0;
      samples_checked = 0;
      RESET = 1'b1;
      p = 21'h0_70E0;
      cfg = '{1'b1, 1'b1, 1'b1, 1'b0, 3'h4, 4'h3, '0};
      tmr = {11{16'h0002}};
      tmr.cool = 16'h0014;
      cyc(8);
      chk({MODE, RELAYS, LAMPS}, 16'h0000);
      @(posedge CLK);
      RESET <= 1'b0;
      t_stop_mode();
      t_faults();
      t_auto();
      t_run();
      t_test();
      wrap_up();
   end
endmodule : testbench
